// ==== tb/dsc_drive_state_bench.sv ====
// Self-checking bench for the drive state command logic.
// Assumes the host model drives the register bus.
`timescale 1ns/1ps
`default_nettype none
module dsc_drive_state_bench import dsc_pkg::*;;
  logic aclk, aresetn, ce, drive_error, stage_overheat, power_en_q, irq_q, dir_a_q, dir_b_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] status_word_q, cur_a_q, cur_b_q;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // Command pattern beside the status word it should give
  logic [19:0] rows [10] = '{20'h6_0031, 20'h7_0033, 20'hF_0037, 20'h7_0033, 20'hF_0037,
                             20'h2_0017, 20'h0_0040, 20'h7_0040, 20'h6_0031, 20'hF_0037};

  dsc_drive_state dut_u (.*);
  dsc_host host_u (.*);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.wr(a, d, rsp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    aresetn = 1'b0;
    ce = 1'b1;
    drive_error = 1'b0;
    stage_overheat = 1'b0;
    settle(12);
    aresetn <= 1'b1;
    settle(3);
    check(32'(status_word_q), 32'h0040);
    host_u.rd(DSC_ADDR_CURRENT, rd, rsp);
    check(rd, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      wr(DSC_ADDR_CTRL, {28'h0, rows[i][19:16]});
      settle(3);
      check(32'(status_word_q), 32'(rows[i][15:0]));
    end
    wr(DSC_ADDR_CURRENT, 32'h0100);
    wr(DSC_ADDR_CONFIG, 32'h0);
    wr(DSC_ADDR_POSITION, 32'h0);
    settle(3);
    check({cur_b_q, cur_a_q}, 32'h0000_0100);
    wr(DSC_ADDR_POSITION, 32'h20);
    settle(3);
    check({14'h0, dir_b_q, dir_a_q, cur_a_q}, 32'h0003_0100);
    wr(DSC_ADDR_OBJ_SEL, 32'h0081_0002);
    host_u.rd(DSC_ADDR_OBJ_DATA, rd, rsp);
    check(rd, 32'h0037);
    wr(DSC_ADDR_OBJ_SEL, 32'h0081_0000);
    host_u.rd(DSC_ADDR_OBJ_DATA, rd, rsp);
    check(rd, 32'h2);
    host_u.rd(8'h24, rd, rsp);
    check(32'(rsp), 32'(DSC_RESP_SLVERR));
    wr(8'h24, 32'h0);
    check(32'(rsp), 32'(DSC_RESP_SLVERR));
    wr(DSC_ADDR_IRQ_MASK, 32'h7);
    wr(DSC_ADDR_IRQ_STAT, 32'h7);
    settle(2);
    check(32'(irq_q), 32'h0);
    stage_overheat <= 1'b1;
    settle(4);
    check({cur_a_q, 15'h0, power_en_q}, 32'h0);
    check(32'(status_word_q), 32'h0008);
    check(32'(irq_q), 32'h1);
    wr(DSC_ADDR_IRQ_MASK, 32'h0);
    settle(2);
    check(32'(irq_q), 32'h0);
    stage_overheat <= 1'b0;
    wr(DSC_ADDR_CTRL, 32'h000F);
    settle(3);
    check(32'(status_word_q), 32'h0008);
    wr(DSC_ADDR_CTRL, 32'h0080);
    settle(3);
    check(32'(status_word_q), 32'h0040);
    wr(DSC_ADDR_CTRL, 32'h0006);
    drive_error <= 1'b1;
    settle(1);
    drive_error <= 1'b0;
    settle(4);
    check(32'(status_word_q), 32'h0008);
    wr(DSC_ADDR_CTRL, 32'h0086);
    settle(3);
    check(32'(status_word_q), 32'h0031);
    aresetn <= 1'b0;
    settle(2);
    aresetn <= 1'b1;
    settle(3);
    check(32'(status_word_q), 32'h0040);
    host_u.rd(DSC_ADDR_CURRENT, rd, rsp);
    check(rd, 32'h0);
    // Setpoint sent again after restart
    wr(DSC_ADDR_CURRENT, 32'h0100);
    check(32'(rsp), 32'(DSC_RESP_OKAY));
    // Clock enable low freezes the state despite an error
    ce <= 1'b0;
    drive_error <= 1'b1;
    settle(3);
    check(32'(status_word_q), 32'h0040);
    ce <= 1'b1;
    drive_error <= 1'b0;
    settle(3);
    check(32'(status_word_q), 32'h0040);
    stop_test();
  end
endmodule
`default_nettype wire

// ==== tb/dsc_host.sv ====
// Host controller model: AXI4-Lite master for the command registers.
// Assumes tasks are called from a process synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module dsc_host
(
  input  wire logic        aclk,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output var  logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  initial
  begin
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
  end

  // Commands go out as control word patterns
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== verilog/dsc_drive_state.sv ====
// Drive state command logic: control word decoding, power state machine,
// status word, object access, current setpoint and power stage control.
// Assumes an AXI4-Lite master, synchronous inputs and a 250 MHz aclk.
//
// What this block does
// - Shutdown x110 enters Ready to switch on
// - Switch on 0111 from ready enters Switched on
// - Enable operation 1111 enters Operation enabled
// - Past Not ready to switch on and Fault reaction active, state changes only on commands or errors
// - Status word reports state as bit combinations
// - Current setpoint resets to zero milliamps
// - Power stage overheating shuts the stage down
// - Full step at position zero drives one winding
// - Objects addressed by index and subindex
// - Disable voltage xx0x returns to Switch on disabled
// - Quick stop x01x performs quick-stop transition
// - Control bit 7 rising edge clears fault
// - 0111 in Operation enabled returns to Switched on
`timescale 1ns/1ps
`default_nettype none
module dsc_drive_state
  import dsc_pkg::*;
#(
  parameter int CUR_W = 16,
  parameter int POS_W = 6
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             s_axi_awvalid,
  output var  logic             s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output var  logic             s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output var  logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output var  logic [1:0]       s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output var  logic             s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  output var  logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output var  logic [31:0]      s_axi_rdata,
  output var  logic [1:0]       s_axi_rresp,
  input  wire logic             drive_error,
  input  wire logic             stage_overheat,
  output var  logic             power_en_q,
  output var  logic [15:0]      status_word_q,
  output var  logic [CUR_W-1:0] cur_a_q,
  output var  logic             dir_a_q,
  output var  logic [CUR_W-1:0] cur_b_q,
  output var  logic             dir_b_q,
  output var  logic             irq_q
);

  dsc_state_t             state_q;
  dsc_state_t             state_d;
  logic [15:0]            ctrl_q;
  logic [CUR_W-1:0]       current_q;
  logic [POS_W-1:0]       position_q;
  logic                   micro_q;
  logic [23:0]            obj_sel_q;
  logic [DSC_IRQ_W-1:0]   irq_stat_q;
  logic [DSC_IRQ_W-1:0]   irq_mask_q;
  logic                   fr_prev_q;
  logic                   heat_prev_q;
  logic                   aw_have_q;
  logic                   w_have_q;
  logic [7:0]             waddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   do_wr;
  logic [31:0]            wmask;
  logic [31:0]            rd_val;
  logic                   rd_ok;
  logic [31:0]            obj_val;
  logic [15:0]            status_d;
  logic [3:0]             cmd;
  logic                   c_shutdown;
  logic                   c_switch_on;
  logic                   c_enable;
  logic                   c_disable_v;
  logic                   c_quick;
  logic                   c_fault_rst;
  logic                   err;
  logic [DSC_IRQ_W-1:0]   irq_ev;

  // Command decoding of the low control bits
  assign cmd         = ctrl_q[3:0];
  assign c_shutdown  = cmd[2:1] == 2'h3 && !cmd[0];
  assign c_switch_on = cmd == 4'h7;
  assign c_enable    = cmd == 4'hF;
  assign c_disable_v = !cmd[1];
  assign c_quick     = cmd[2:1] == 2'h1;
  assign c_fault_rst = ctrl_q[DSC_FAULT_RESET_BIT] && !fr_prev_q;
  assign err         = drive_error || stage_overheat;

  // Power state transitions
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DSC_NOT_READY:   state_d = DSC_SW_ON_DIS;
      DSC_SW_ON_DIS:
      begin
        if (c_shutdown)
          state_d = DSC_READY;
      end
      DSC_READY:
      begin
        if (c_disable_v || c_quick)
          state_d = DSC_SW_ON_DIS;
        else if (c_switch_on)
          state_d = DSC_SWITCHED_ON;
        else if (c_enable)
          state_d = DSC_OP_ENABLED;
      end
      DSC_SWITCHED_ON:
      begin
        if (c_disable_v || c_quick)
          state_d = DSC_SW_ON_DIS;
        else if (c_shutdown)
          state_d = DSC_READY;
        else if (c_enable)
          state_d = DSC_OP_ENABLED;
      end
      DSC_OP_ENABLED:
      begin
        if (c_disable_v)
          state_d = DSC_SW_ON_DIS;
        else if (c_quick)
          state_d = DSC_QUICK_STOP;
        else if (c_shutdown)
          state_d = DSC_READY;
        else if (c_switch_on)
          state_d = DSC_SWITCHED_ON;
      end
      DSC_QUICK_STOP:
      begin
        if (c_disable_v)
          state_d = DSC_SW_ON_DIS;
        else if (c_enable)
          state_d = DSC_OP_ENABLED;
      end
      DSC_FAULT_REACT: state_d = DSC_FAULT;
      DSC_FAULT:
      begin
        if (c_fault_rst && !err)
          state_d = DSC_SW_ON_DIS;
      end
      default:         state_d = DSC_NOT_READY;
    endcase
    if (err && state_q != DSC_FAULT_REACT && state_q != DSC_FAULT)
      state_d = DSC_FAULT_REACT;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q   <= DSC_NOT_READY;
      fr_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q   <= state_d;
      fr_prev_q <= ctrl_q[DSC_FAULT_RESET_BIT];
    end
  end

  // Status word: bit 0 ready, 1 on, 2 enabled, 3 fault, 4 voltage, 5 qs, 6 disabled
  always_comb
  begin
    case (state_q)
      DSC_NOT_READY:   status_d = 16'h0000;
      DSC_SW_ON_DIS:   status_d = 16'h0040;
      DSC_READY:       status_d = 16'h0031;
      DSC_SWITCHED_ON: status_d = 16'h0033;
      DSC_OP_ENABLED:  status_d = 16'h0037;
      DSC_QUICK_STOP:  status_d = 16'h0017;
      DSC_FAULT_REACT: status_d = 16'h001F;
      DSC_FAULT:       status_d = 16'h0008;
      default:         status_d = 16'h0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_word_q <= 16'h0000;
    else if (ce)
      status_word_q <= status_d;
  end

  // Power stage enable, cut at once on overheating
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power_en_q <= 1'b0;
    else if (ce)
      power_en_q <= state_d == DSC_OP_ENABLED && !stage_overheat;
  end

  dsc_winding_drive #(
    .POS_W (POS_W),
    .CUR_W (CUR_W)
  ) u_wind (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .power_en (power_en_q),
    .micro_en (micro_q),
    .position (position_q),
    .current  (current_q),
    .cur_a_q  (cur_a_q),
    .dir_a_q  (dir_a_q),
    .cur_b_q  (cur_b_q),
    .dir_b_q  (dir_b_q)
  );

  // Write channel capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DSC_RESP_OKAY;
      waddr_q       <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_q       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_q[1:0] == 2'h0 && waddr_q <= DSC_ADDR_IRQ_MASK)
                        ? DSC_RESP_OKAY : DSC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q     <= DSC_CTRL_RST;
      current_q  <= CUR_W'(DSC_CURRENT_RST);
      position_q <= POS_W'(DSC_POSITION_RST);
      micro_q    <= DSC_MICRO_RST;
      obj_sel_q  <= DSC_OBJ_SEL_RST;
      irq_mask_q <= '0;
    end
    else if (ce && do_wr)
    begin
      case (waddr_q)
        DSC_ADDR_CTRL:     ctrl_q     <= (ctrl_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
        DSC_ADDR_CURRENT:  current_q  <= (current_q & ~wmask[CUR_W-1:0])
                                         | (wdata_q[CUR_W-1:0] & wmask[CUR_W-1:0]);
        DSC_ADDR_POSITION: position_q <= wstrb_q[0] ? wdata_q[POS_W-1:0] : position_q;
        DSC_ADDR_CONFIG:   micro_q    <= wstrb_q[0] ? wdata_q[DSC_CFG_MICRO_BIT] : micro_q;
        DSC_ADDR_OBJ_SEL:  obj_sel_q  <= (obj_sel_q & ~wmask[23:0])
                                         | (wdata_q[23:0] & wmask[23:0]);
        DSC_ADDR_IRQ_MASK: irq_mask_q <= wstrb_q[0] ? wdata_q[DSC_IRQ_W-1:0] : irq_mask_q;
        default:           micro_q    <= micro_q;
      endcase
    end
  end

  // Interrupt events, set wins over write-one-to-clear
  assign irq_ev[DSC_IRQ_STATE_BIT] = state_d != state_q;
  assign irq_ev[DSC_IRQ_FAULT_BIT] = state_d == DSC_FAULT_REACT && state_q != DSC_FAULT_REACT;
  assign irq_ev[DSC_IRQ_HEAT_BIT]  = stage_overheat && !heat_prev_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q  <= '0;
      heat_prev_q <= 1'b0;
      irq_q       <= 1'b0;
    end
    else if (ce)
    begin
      heat_prev_q <= stage_overheat;
      if (do_wr && waddr_q == DSC_ADDR_IRQ_STAT && wstrb_q[0])
        irq_stat_q <= (irq_stat_q & ~wdata_q[DSC_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Object dictionary access by index and subindex
  always_comb
  begin
    case (obj_sel_q)
      {DSC_OBJ_DRIVE_CTRL, 8'h00}:            obj_val = {24'h000000, DSC_SUB_COUNT_CTRL};
      {DSC_OBJ_DRIVE_CTRL, DSC_SUB_CTRL_WORD}: obj_val = {16'h0000, ctrl_q};
      {DSC_OBJ_DRIVE_CTRL, DSC_SUB_STAT_WORD}: obj_val = {16'h0000, status_word_q};
      {DSC_OBJ_CURRENT, 8'h00}:               obj_val = {24'h000000, DSC_SUB_COUNT_CUR};
      {DSC_OBJ_CURRENT, DSC_SUB_CUR_TARGET}:  obj_val = 32'(current_q);
      default:                                obj_val = 32'h00000000;
    endcase
  end

  always_comb
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      DSC_ADDR_CTRL:     rd_val = {16'h0000, ctrl_q};
      DSC_ADDR_STATUS:   rd_val = {16'h0000, status_word_q};
      DSC_ADDR_CURRENT:  rd_val = 32'(current_q);
      DSC_ADDR_POSITION: rd_val = 32'(position_q);
      DSC_ADDR_CONFIG:   rd_val = 32'(micro_q);
      DSC_ADDR_OBJ_SEL:  rd_val = {8'h00, obj_sel_q};
      DSC_ADDR_OBJ_DATA: rd_val = obj_val;
      DSC_ADDR_IRQ_STAT: rd_val = 32'(irq_stat_q);
      DSC_ADDR_IRQ_MASK: rd_val = 32'(irq_mask_q);
      default:
      begin
        rd_val = 32'h00000000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= DSC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? DSC_RESP_OKAY : DSC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  shutdown_to_ready_a: assert property (
    (ce && !err && c_shutdown && (state_q == DSC_SW_ON_DIS || state_q == DSC_SWITCHED_ON))
      |=> state_q == DSC_READY ##1 (status_word_q == 16'h0031 || !$past(ce)))
    else $error("shutdown did not reach ready to switch on");

  switch_on_a: assert property (
    (ce && !err && c_switch_on && state_q == DSC_READY) |=> state_q == DSC_SWITCHED_ON)
    else $error("switch on did not reach switched on");

  enable_op_a: assert property (
    (ce && !err && c_enable && (state_q == DSC_READY || state_q == DSC_SWITCHED_ON))
      |=> state_q == DSC_OP_ENABLED && power_en_q)
    else $error("enable operation did not enable the stage");

  status_match_a: assert property (
    ce |=> status_word_q == (($past(state_q) == DSC_OP_ENABLED) ? 16'h0037 : status_word_q)
      && (status_word_q[2] == ($past(state_q) == DSC_OP_ENABLED
      || $past(state_q) == DSC_QUICK_STOP || $past(state_q) == DSC_FAULT_REACT)))
    else $error("status word does not match the state");

  overheat_off_a: assert property (
    (ce && stage_overheat) |=> !power_en_q [*2])
    else $error("power stage stayed on while overheated");

  disable_volt_a: assert property (
    (ce && !err && c_disable_v && state_q inside {DSC_READY, DSC_SWITCHED_ON,
      DSC_OP_ENABLED, DSC_QUICK_STOP}) |=> state_q == DSC_SW_ON_DIS)
    else $error("disable voltage did not reach switch on disabled");

  quick_stop_a: assert property (
    (ce && !err && c_quick && state_q == DSC_OP_ENABLED) |=> state_q == DSC_QUICK_STOP)
    else $error("quick stop not taken from operation enabled");

  fault_reset_a: assert property (
    (ce && state_q == DSC_FAULT && !err && ctrl_q[7] && !fr_prev_q)
      |=> state_q == DSC_SW_ON_DIS)
    else $error("fault reset edge did not clear the fault");

  fault_hold_a: assert property (
    (ce && state_q == DSC_FAULT && !(ctrl_q[7] && !fr_prev_q)) |=> state_q == DSC_FAULT)
    else $error("fault left without a reset edge");

  disable_op_a: assert property (
    (ce && !err && c_switch_on && state_q == DSC_OP_ENABLED) |=> state_q == DSC_SWITCHED_ON)
    else $error("disable operation did not reach switched on");

  no_cmd_hold_a: assert property (
    (ce && !err && state_q == DSC_SW_ON_DIS && !c_shutdown) |=> $stable(state_q))
    else $error("state changed without a valid command");

  fault_entry_a: assert property (
    (ce && err && state_q != DSC_FAULT && state_q != DSC_FAULT_REACT)
      |=> state_q == DSC_FAULT_REACT)
    else $error("error did not start the fault reaction");

endmodule
`default_nettype wire

// ==== verilog/dsc_pkg.sv ====
// Constants, state codes and register map for the drive state command logic.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
package dsc_pkg;

  // Register byte addresses
  localparam logic [7:0] DSC_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] DSC_ADDR_STATUS   = 8'h04;
  localparam logic [7:0] DSC_ADDR_CURRENT  = 8'h08;
  localparam logic [7:0] DSC_ADDR_POSITION = 8'h0C;
  localparam logic [7:0] DSC_ADDR_CONFIG   = 8'h10;
  localparam logic [7:0] DSC_ADDR_OBJ_SEL  = 8'h14;
  localparam logic [7:0] DSC_ADDR_OBJ_DATA = 8'h18;
  localparam logic [7:0] DSC_ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] DSC_ADDR_IRQ_MASK = 8'h20;

  // Values after reset
  localparam logic [15:0] DSC_CTRL_RST     = 16'h0000;
  localparam logic [15:0] DSC_CURRENT_RST  = 16'h0000;
  localparam logic [5:0]  DSC_POSITION_RST = 6'h00;
  localparam logic        DSC_MICRO_RST    = 1'b1;
  localparam logic [23:0] DSC_OBJ_SEL_RST  = 24'h000000;

  // Field positions
  localparam int DSC_FAULT_RESET_BIT = 7;
  localparam int DSC_CFG_MICRO_BIT   = 0;
  localparam int DSC_IRQ_W           = 3;
  localparam int DSC_IRQ_STATE_BIT   = 0;
  localparam int DSC_IRQ_FAULT_BIT   = 1;
  localparam int DSC_IRQ_HEAT_BIT    = 2;

  // Object numbers: index in bits 23:8, subindex in bits 7:0
  localparam logic [15:0] DSC_OBJ_DRIVE_CTRL = 16'h8100;
  localparam logic [15:0] DSC_OBJ_CURRENT    = 16'h8600;
  localparam logic [7:0]  DSC_SUB_CTRL_WORD  = 8'h01;
  localparam logic [7:0]  DSC_SUB_STAT_WORD  = 8'h02;
  localparam logic [7:0]  DSC_SUB_CUR_TARGET = 8'h03;
  localparam logic [7:0]  DSC_SUB_COUNT_CTRL = 8'h02;
  localparam logic [7:0]  DSC_SUB_COUNT_CUR  = 8'h03;

  // Winding drive: steps per electrical period and steps per quadrant
  localparam int DSC_STEPS_PER_PERIOD = 64;
  localparam int DSC_QUAD_STEPS       = 16;

  // Bus answers
  localparam logic [1:0] DSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DSC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DSC_NOT_READY   = 3'b000,
    DSC_SW_ON_DIS   = 3'b001,
    DSC_READY       = 3'b010,
    DSC_SWITCHED_ON = 3'b011,
    DSC_OP_ENABLED  = 3'b100,
    DSC_QUICK_STOP  = 3'b101,
    DSC_FAULT_REACT = 3'b110,
    DSC_FAULT       = 3'b111
  } dsc_state_t;

endpackage

// ==== verilog/dsc_winding_drive.sv ====
// Two-winding current command generator for the stepper power stage.
// Assumes position counts in steps of 1/64 of an electrical period.
`timescale 1ns/1ps
`default_nettype none
module dsc_winding_drive
  import dsc_pkg::*;
#(
  parameter int POS_W = 6,
  parameter int CUR_W = 16
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             power_en,
  input  wire logic             micro_en,
  input  wire logic [POS_W-1:0] position,
  input  wire logic [CUR_W-1:0] current,
  output var  logic [CUR_W-1:0] cur_a_q,
  output var  logic             dir_a_q,
  output var  logic [CUR_W-1:0] cur_b_q,
  output var  logic             dir_b_q
);

  logic [1:0]       quad;
  logic [3:0]       frac;
  logic [CUR_W+4:0] prod_b;
  logic [CUR_W+4:0] prod_a;
  logic [CUR_W-1:0] mag_a_d;
  logic [CUR_W-1:0] mag_b_d;

  assign quad   = position[POS_W-1 -: 2];
  assign frac   = position[3:0];
  assign prod_b = current * frac;
  assign prod_a = current * (5'(DSC_QUAD_STEPS) - {1'b0, frac});

  // Full step drives one winding; micro step shares current linearly
  always_comb
  begin
    if (!micro_en)
    begin
      mag_a_d = quad[0] ? '0 : current;
      mag_b_d = quad[0] ? current : '0;
    end
    else if (!quad[0])
    begin
      mag_a_d = prod_a[CUR_W+3:4];
      mag_b_d = prod_b[CUR_W+3:4];
    end
    else
    begin
      mag_a_d = prod_b[CUR_W+3:4];
      mag_b_d = prod_a[CUR_W+3:4];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_a_q <= '0;
      cur_b_q <= '0;
      dir_a_q <= 1'b0;
      dir_b_q <= 1'b0;
    end
    else if (ce)
    begin
      cur_a_q <= power_en ? mag_a_d : '0;
      cur_b_q <= power_en ? mag_b_d : '0;
      dir_a_q <= quad[1] ^ quad[0];
      dir_b_q <= quad[1];
    end
  end

  full_step_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !micro_en && position == '0) |=> (cur_b_q == '0 && cur_a_q == $past(current)
      && !dir_a_q) || !$past(power_en))
    else $error("full step at position zero must drive winding A only");

endmodule
`default_nettype wire
